// ==== rtl/sys_hint_pkg.sv ====
package sys_hint_pkg;

  // Instruction classes handled by this executor
  typedef enum logic [3:0] {
    OP_MASK_CHANGE,
    OP_ORDER_BARRIER,
    OP_COMPLETE_BARRIER,
    OP_REFETCH_BARRIER,
    OP_SPEC_READ,
    OP_SPEC_WRITE,
    OP_NO_OPERATION,
    OP_EVENT_BROADCAST,
    OP_SUPERVISOR_CALL,
    OP_EVENT_WAIT,
    OP_INT_WAIT
  } op_type;

  // Special register selectors
  typedef enum logic [3:0] {
    SEL_APP,
    SEL_APP_INT,
    SEL_APP_EXEC,
    SEL_INT_EXEC,
    SEL_INT,
    SEL_EXEC,
    SEL_PSW,
    SEL_IRQ_MASK,
    SEL_BASE_PRI,
    SEL_RAISE_ALIAS,
    SEL_FAULT_MASK,
    SEL_OTHER
  } spec_sel_type;

  // One decoded instruction as handed over by the front end
  typedef struct packed {
    op_type op;
    logic mask_set_form;
    logic pick_irq_mask;
    logic pick_fault_mask;
    spec_sel_type spec_sel;
    logic [7:0] imm8;
    logic [31:0] source_operand;
  } instr_type;

  // Condition flags live in the top five bits of the status word
  localparam int FLAG_MSB = 31;
  localparam int FLAG_LSB = 27;
  localparam int FLAG_W = 5;
  localparam int PRI_W = 8;

  // Register bus map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam int CTRL_WAKE_PEND_BIT = 0;
  localparam int CTRL_DBG_EN_BIT = 1;
  localparam int ST_IRQ_MASK_BIT = 0;
  localparam int ST_FAULT_MASK_BIT = 1;
  localparam int ST_EVENT_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_DRAIN_BIT = 4;
  localparam int ST_HOLD_BIT = 5;
  localparam int ST_PRI_LSB = 8;
  localparam int ST_PRI_MSB = 15;

  // Reset values
  localparam logic [PRI_W-1:0] PRI_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ==== rtl/system_hint_barrier_exec.sv ====
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Mask change alters only the priority mask and fault mask picked by its flags.
// - Clear form clears each picked mask bit; set form sets each picked bit.
// - Unprivileged mask change does nothing at all.
// - Order barrier holds later memory accesses until earlier ones finish; others flow.
// - Completion barrier finishes only when all earlier memory accesses completed.
// - Nothing after the completion barrier executes before it finishes.
// - Refetch barrier flushes the pipeline so following instructions fetch again.
// - Status word reads return zero in execution-state and interrupt-number fields.
// - Reading the raise alias returns the base priority threshold.
// - Unprivileged special writes reach only the application word; privileged reach all.
// - Unprivileged status word writes drop unallocated and execution-state bits.
// - Raise alias writes only if source nonzero and threshold zero or above source.
// - Writing the application word loads the flags from the source bits.
// - No-operation hint has no architectural effect and may take no time.
// - Event broadcast signals all processors and sets the local event register.
// - Supervisor call raises its exception; the immediate is ignored.
// - Event wait with register clear sleeps until an enabled wake condition.
// - Event wait with register set clears it and continues at once.
// - Interrupt wait sleeps until interrupt taken, masked one pends, or debug request.
// - Only the special write to the application word changes the flags.
module system_hint_barrier_exec
  import sys_hint_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Instruction stream
  input wire logic instr_valid,
  input var instr_type instr,
  input wire logic privileged,
  output logic instr_ready_reg,
  output logic [31:0] rd_data_reg,
  output logic rd_valid_reg,
  // Memory system
  input wire logic mem_busy,
  output logic mem_hold_reg,
  output logic flush_reg,
  // Exception logic and debug
  input wire logic exc_take,
  input wire logic exc_new_pending,
  input wire logic irq_masked_pending,
  input wire logic dbg_req,
  output logic svc_req_reg,
  output logic sleeping_reg,
  output logic interrupt_priority_mask_reg,
  output logic fault_mask_a_reg,
  output logic [PRI_W-1:0] base_priority_threshold_reg,
  output logic [FLAG_W-1:0] cond_flags_reg,
  // Events between processors
  input wire logic event_in,
  output logic event_out_reg,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_reg,
  output logic pready_reg,
  output logic pslverr_reg
);

  typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_SLEEP_EVT, ST_SLEEP_INT} state_type;

  // Which selectors carry the application flags
  function automatic logic has_app(input spec_sel_type s);
    return (s == SEL_APP) || (s == SEL_APP_INT) || (s == SEL_APP_EXEC) || (s == SEL_PSW);
  endfunction

  state_type state_reg, state_next;
  logic ev_meta_reg, ev_sync_reg, ev_last_reg;
  logic event_reg, event_next;
  logic wake_pend_reg, wake_pend_next, dbg_en_reg, dbg_en_next;
  logic ready_next, rd_valid_next, hold_next, flush_next, svc_next, sleep_next, evo_next;
  logic irq_mask_next, fault_mask_next;
  logic [PRI_W-1:0] pri_next;
  logic [FLAG_W-1:0] flags_next;
  logic [31:0] rd_data_next, prdata_next;
  logic pready_next, pslverr_next;
  logic take, ext_event, wake_evt, wake_int, apb_done, hit_ctrl, hit_status;
  logic [PRI_W-1:0] src_pri;

  assign take = instr_valid && instr_ready_reg;
  assign ext_event = ev_sync_reg && !ev_last_reg;
  assign src_pri = instr.source_operand[PRI_W-1:0];
  assign wake_evt = exc_take || (exc_new_pending && wake_pend_reg) || (dbg_req && dbg_en_reg)
                    || ext_event;
  assign wake_int = exc_take || irq_masked_pending || dbg_req;

  // Event pin is asynchronous: two flops before the edge detector
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ev_meta_reg <= 1'b0;
      ev_sync_reg <= 1'b0;
      ev_last_reg <= 1'b0;
    end else begin
      ev_meta_reg <= event_in;
      ev_sync_reg <= ev_meta_reg;
      ev_last_reg <= ev_sync_reg;
    end
  end

  // Instruction execution, sleep and barrier sequencing
  always_comb begin
    state_next = state_reg;
    event_next = event_reg;
    hold_next = mem_hold_reg && mem_busy; // Release once older accesses drain
    flush_next = 1'b0;
    svc_next = 1'b0;
    evo_next = 1'b0;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    irq_mask_next = interrupt_priority_mask_reg;
    fault_mask_next = fault_mask_a_reg;
    pri_next = base_priority_threshold_reg;
    flags_next = cond_flags_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          case (instr.op)
            OP_MASK_CHANGE: begin
              if (privileged) begin
                if (instr.pick_irq_mask) irq_mask_next = instr.mask_set_form;
                if (instr.pick_fault_mask) fault_mask_next = instr.mask_set_form;
              end
            end
            // Only memory traffic waits; this instruction retires at once
            OP_ORDER_BARRIER: hold_next = mem_busy;
            OP_COMPLETE_BARRIER: begin
              hold_next = mem_busy;
              if (mem_busy) state_next = ST_DRAIN;
            end
            OP_REFETCH_BARRIER: flush_next = 1'b1;
            OP_SPEC_READ: begin
              rd_valid_next = 1'b1;
              rd_data_next = WORD_ZERO; // Exec and interrupt fields stay zero
              case (instr.spec_sel)
                SEL_IRQ_MASK: rd_data_next[0] = interrupt_priority_mask_reg;
                SEL_FAULT_MASK: rd_data_next[0] = fault_mask_a_reg;
                SEL_BASE_PRI, SEL_RAISE_ALIAS: rd_data_next[PRI_W-1:0] =
                  base_priority_threshold_reg;
                default: begin
                  if (has_app(instr.spec_sel)) rd_data_next[FLAG_MSB:FLAG_LSB] = cond_flags_reg;
                end
              endcase
            end
            OP_SPEC_WRITE: begin
              // Flags only; exec and unallocated bits are never stored
              if (has_app(instr.spec_sel))
                flags_next = instr.source_operand[FLAG_MSB:FLAG_LSB];
              if (privileged) begin
                case (instr.spec_sel)
                  SEL_IRQ_MASK: irq_mask_next = instr.source_operand[0];
                  SEL_FAULT_MASK: fault_mask_next = instr.source_operand[0];
                  SEL_BASE_PRI: pri_next = src_pri;
                  SEL_RAISE_ALIAS: begin
                    if ((src_pri != PRI_RESET) && ((base_priority_threshold_reg == PRI_RESET)
                        || (src_pri < base_priority_threshold_reg)))
                      pri_next = src_pri;
                  end
                  default: pri_next = base_priority_threshold_reg;
                endcase
              end
            end
            OP_EVENT_BROADCAST: begin
              evo_next = 1'b1;
              event_next = 1'b1;
            end
            OP_SUPERVISOR_CALL: svc_next = 1'b1; // Immediate deliberately unused
            OP_EVENT_WAIT: begin
              if (event_reg) event_next = 1'b0;
              else state_next = ST_SLEEP_EVT;
            end
            OP_INT_WAIT: state_next = ST_SLEEP_INT;
            default: state_next = ST_IDLE; // No-operation hint retires silently
          endcase
        end
      end
      ST_DRAIN: if (!mem_busy) state_next = ST_IDLE;
      ST_SLEEP_EVT: if (wake_evt) state_next = ST_IDLE;
      ST_SLEEP_INT: if (wake_int) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    // Set wins over the wait's clear; an event that wakes a sleep is consumed by it
    if (ext_event && (state_reg != ST_SLEEP_EVT)) event_next = 1'b1;
    ready_next = (state_next == ST_IDLE);
    sleep_next = (state_next == ST_SLEEP_EVT) || (state_next == ST_SLEEP_INT);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      event_reg <= 1'b0;
      instr_ready_reg <= 1'b1;
      rd_data_reg <= WORD_ZERO;
      rd_valid_reg <= 1'b0;
      mem_hold_reg <= 1'b0;
      flush_reg <= 1'b0;
      svc_req_reg <= 1'b0;
      sleeping_reg <= 1'b0;
      event_out_reg <= 1'b0;
      interrupt_priority_mask_reg <= 1'b0;
      fault_mask_a_reg <= 1'b0;
      base_priority_threshold_reg <= PRI_RESET;
      cond_flags_reg <= FLAGS_RESET;
    end else begin
      state_reg <= state_next;
      event_reg <= event_next;
      instr_ready_reg <= ready_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      mem_hold_reg <= hold_next;
      flush_reg <= flush_next;
      svc_req_reg <= svc_next;
      sleeping_reg <= sleep_next;
      event_out_reg <= evo_next;
      interrupt_priority_mask_reg <= irq_mask_next;
      fault_mask_a_reg <= fault_mask_next;
      base_priority_threshold_reg <= pri_next;
      cond_flags_reg <= flags_next;
    end
  end

  // APB slave with one wait state so read data comes from a flop
  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign apb_done = psel && penable && pready_reg;

  always_comb begin
    wake_pend_next = wake_pend_reg;
    dbg_en_next = dbg_en_reg;
    pready_next = psel && penable && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next = WORD_ZERO;
    if (psel && penable && !pready_reg) begin
      pslverr_next = !(hit_ctrl || (hit_status && !pwrite)); // Status is read-only
      if (hit_ctrl) begin
        prdata_next[CTRL_WAKE_PEND_BIT] = wake_pend_reg;
        prdata_next[CTRL_DBG_EN_BIT] = dbg_en_reg;
      end else if (hit_status) begin
        prdata_next[ST_IRQ_MASK_BIT] = interrupt_priority_mask_reg;
        prdata_next[ST_FAULT_MASK_BIT] = fault_mask_a_reg;
        prdata_next[ST_EVENT_BIT] = event_reg;
        prdata_next[ST_SLEEP_BIT] = sleeping_reg;
        prdata_next[ST_DRAIN_BIT] = (state_reg == ST_DRAIN);
        prdata_next[ST_HOLD_BIT] = mem_hold_reg;
        prdata_next[ST_PRI_MSB:ST_PRI_LSB] = base_priority_threshold_reg;
        prdata_next[FLAG_MSB:FLAG_LSB] = cond_flags_reg;
      end
    end
    if (apb_done && pwrite && hit_ctrl) begin
      wake_pend_next = pwdata[CTRL_WAKE_PEND_BIT];
      dbg_en_next = pwdata[CTRL_DBG_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wake_pend_reg <= 1'b0;
      dbg_en_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= WORD_ZERO;
    end else begin
      wake_pend_reg <= wake_pend_next;
      dbg_en_reg <= dbg_en_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Checks on the executor
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_mask_unpriv;
    take && instr.op == OP_MASK_CHANGE && !privileged |=>
      $stable(interrupt_priority_mask_reg) && $stable(fault_mask_a_reg);
  endproperty
  a_mask_unpriv: assert property (p_mask_unpriv) else $error("unprivileged mask change acted");

  property p_mask_form;
    take && instr.op == OP_MASK_CHANGE && privileged && instr.pick_irq_mask |=>
      interrupt_priority_mask_reg == $past(instr.mask_set_form);
  endproperty
  a_mask_form: assert property (p_mask_form) else $error("mask form not applied");

  property p_flags_kept;
    take && instr.op != OP_SPEC_WRITE |=> $stable(cond_flags_reg);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed unexpectedly");

  property p_drain_stall;
    take && instr.op == OP_COMPLETE_BARRIER && mem_busy |=> !instr_ready_reg;
  endproperty
  a_drain_stall: assert property (p_drain_stall) else $error("completion barrier not stalling");

  property p_drain_end;
    state_reg == ST_DRAIN && !mem_busy |=> instr_ready_reg && !mem_hold_reg;
  endproperty
  a_drain_end: assert property (p_drain_end) else $error("completion barrier did not finish");

  property p_order_hold;
    take && instr.op == OP_ORDER_BARRIER && mem_busy |=> mem_hold_reg && instr_ready_reg;
  endproperty
  a_order_hold: assert property (p_order_hold) else $error("order barrier wrong");

  // A second barrier taken right behind the first legitimately stretches the pulse
  property p_flush;
    take && instr.op == OP_REFETCH_BARRIER |=>
      flush_reg ##1 (!flush_reg || $past(take && instr.op == OP_REFETCH_BARRIER));
  endproperty
  a_flush: assert property (p_flush) else $error("refetch flush not one pulse");

  property p_broadcast;
    take && instr.op == OP_EVENT_BROADCAST |=> event_out_reg && event_reg;
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("broadcast missing");

  property p_svc;
    take && instr.op == OP_SUPERVISOR_CALL |=>
      svc_req_reg ##1 (!svc_req_reg || $past(take && instr.op == OP_SUPERVISOR_CALL));
  endproperty
  a_svc: assert property (p_svc) else $error("supervisor call not raised");

  property p_raise_zero;
    take && instr.op == OP_SPEC_WRITE && instr.spec_sel == SEL_RAISE_ALIAS && src_pri == PRI_RESET
      |=> $stable(base_priority_threshold_reg);
  endproperty
  a_raise_zero: assert property (p_raise_zero) else $error("raise alias wrote zero");

  property p_read_zero;
    take && instr.op == OP_SPEC_READ && (instr.spec_sel == SEL_INT_EXEC) |=>
      rd_valid_reg && rd_data_reg == WORD_ZERO;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("status fields not zero");

  property p_wait_set;
    take && instr.op == OP_EVENT_WAIT && event_reg && !ext_event |=>
      instr_ready_reg && !event_reg && !sleeping_reg;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("event wait did not continue");

  // Alias reads mirror the threshold held when the read was taken
  property p_alias_read;
    take && instr.op == OP_SPEC_READ && instr.spec_sel == SEL_RAISE_ALIAS |=>
      rd_valid_reg && rd_data_reg == 32'($past(base_priority_threshold_reg));
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("raise alias read wrong");

  // Unprivileged writes must never reach masks or threshold
  property p_unpriv_write;
    take && instr.op == OP_SPEC_WRITE && !privileged |=> $stable(base_priority_threshold_reg)
      && $stable(interrupt_priority_mask_reg) && $stable(fault_mask_a_reg);
  endproperty
  a_unpriv_write: assert property (p_unpriv_write) else $error("unprivileged write leaked");

  property p_int_wake;
    state_reg == ST_SLEEP_INT && wake_int |=> instr_ready_reg && !sleeping_reg;
  endproperty
  a_int_wake: assert property (p_int_wake) else $error("interrupt wait did not wake");

  c_wait_continue: cover property (take && instr.op == OP_EVENT_WAIT && event_reg);

  c_evt_sleep: cover property (state_reg == ST_SLEEP_EVT ##1 state_reg == ST_IDLE);
  c_int_sleep: cover property (state_reg == ST_SLEEP_INT ##1 state_reg == ST_IDLE);
  c_drain: cover property (state_reg == ST_DRAIN ##1 state_reg == ST_IDLE);
  c_raise: cover property (take && instr.op == OP_SPEC_WRITE && instr.spec_sel == SEL_RAISE_ALIAS);

endmodule

`default_nettype wire

// ==== test/mem_event_partner.sv ====
`timescale 1ns/1ns
`default_nettype none

module mem_event_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Requests from the bench
  input wire logic busy_start,
  input wire logic [3:0] busy_len,
  input wire logic event_start,
  // Far side of the executor
  output logic mem_busy,
  output logic event_in
);
  logic [3:0] busy_cnt_reg;
  logic [1:0] evt_cnt_reg;

  // Older accesses drain after busy_len cycles; short lengths act as a prompt memory
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt_reg <= 4'h0;
      evt_cnt_reg <= 2'h0;
    end else begin
      if (busy_start)
        busy_cnt_reg <= busy_len;
      else if (busy_cnt_reg != 4'h0)
        busy_cnt_reg <= busy_cnt_reg - 4'h1;
      if (event_start)
        evt_cnt_reg <= 2'h3;
      else if (evt_cnt_reg != 2'h0)
        evt_cnt_reg <= evt_cnt_reg - 2'h1;
    end
  end

  // Event held three cycles so the receiving synchroniser cannot miss it
  assign mem_busy = busy_cnt_reg != 4'h0;
  assign event_in = evt_cnt_reg != 2'h0;
endmodule

`default_nettype wire

// ==== test/system_hint_barrier_exec_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module system_hint_barrier_exec_tb_top import sys_hint_pkg::*;;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic instr_valid = 1'h0, privileged = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  instr_type instr = '0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, v;
  logic [4:0] wake_v = 5'h00;
  logic busy_start = 1'h0;
  logic [3:0] busy_len = 4'h0;
  logic instr_ready_reg, rd_valid_reg, mem_busy, mem_hold_reg, flush_reg, svc_req_reg;
  logic sleeping_reg, interrupt_priority_mask_reg, fault_mask_a_reg, event_in, event_out_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] rd_data_reg, prdata_reg;
  logic [PRI_W-1:0] base_priority_threshold_reg;
  logic [FLAG_W-1:0] cond_flags_reg;
  int n_mismatch = 0, comparisons = 0, n_svc = 0, n_flush = 0, n_evt = 0;
  integer seed;
  logic [31:0] q_rd[$];
  logic [32:0] q_apb[$];
  logic [32:0] apb_exp;
  logic pm = 1'h0, fm = 1'h0;
  logic [7:0] thr = 8'h00;
  logic [4:0] flags = 5'h00;
  logic [7:0] alias_v [5] = '{8'h00, 8'h60, 8'h70, 8'h60, 8'h20};
  spec_sel_type wsel [3] = '{SEL_APP, SEL_PSW, SEL_BASE_PRI};

  always #10 clk_sys = ~clk_sys;

  system_hint_barrier_exec u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr(instr), .privileged(privileged),
    .instr_ready_reg(instr_ready_reg), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
    .mem_busy(mem_busy), .mem_hold_reg(mem_hold_reg), .flush_reg(flush_reg),
    .exc_take(wake_v[3]), .exc_new_pending(wake_v[0]), .irq_masked_pending(wake_v[2]),
    .dbg_req(wake_v[1]), .svc_req_reg(svc_req_reg), .sleeping_reg(sleeping_reg),
    .interrupt_priority_mask_reg(interrupt_priority_mask_reg),
    .fault_mask_a_reg(fault_mask_a_reg), .base_priority_threshold_reg(base_priority_threshold_reg),
    .cond_flags_reg(cond_flags_reg), .event_in(event_in), .event_out_reg(event_out_reg),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_reg(prdata_reg), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg));

  mem_event_partner u_partner (.clk_sys(clk_sys), .arst_n(arst_n), .busy_start(busy_start),
    .busy_len(busy_len), .event_start(wake_v[4]), .mem_busy(mem_busy), .event_in(event_in));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Pulse counters and the scoreboard for read results
  always @(posedge clk_sys) begin
    n_svc += (svc_req_reg === 1'h1);
    n_flush += (flush_reg === 1'h1);
    n_evt += (event_out_reg === 1'h1);
    if (rd_valid_reg === 1'h1)
      chk("rd_data", rd_data_reg, q_rd.size() ? q_rd.pop_front() : 32'hXXXX_XXXX);
    if (psel && penable && pready_reg === 1'h1) begin
      apb_exp = q_apb.pop_front();
      chk("pslverr", {31'h0, pslverr_reg}, {31'h0, apb_exp[32]});
      if (!pwrite)
        chk("prdata", prdata_reg, apb_exp[31:0]);
    end
  end

  function automatic instr_type mk(input op_type o, input logic [2:0] f, input spec_sel_type s,
                                   input logic [31:0] src);
    mk = '{o, f[2], f[1], f[0], s, 8'($random(seed)), src};
  endfunction

  function automatic logic [31:0] exp_rd(input spec_sel_type s);
    case (s)
      SEL_IRQ_MASK: exp_rd = {31'h0, pm};
      SEL_FAULT_MASK: exp_rd = {31'h0, fm};
      SEL_BASE_PRI, SEL_RAISE_ALIAS: exp_rd = {24'h0, thr};
      SEL_INT_EXEC, SEL_INT, SEL_EXEC, SEL_OTHER: exp_rd = 32'h0;
      default: exp_rd = {flags, 27'h0};
    endcase
  endfunction

  // Offers one instruction and returns just after the edge that takes it
  task automatic issue(input instr_type i, input logic pr);
    logic r;
    if (clk_sys === 1'h0)
      @(posedge clk_sys);
    instr <= i;
    privileged <= pr;
    instr_valid <= 1'h1;
    r = 1'h0;
    for (int k = 0; k < 60 && !r; k++) begin
      @(negedge clk_sys);
      r = (instr_ready_reg === 1'h1);
      @(posedge clk_sys);
    end
    if (!r) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic run(input op_type o);
    issue(mk(o, 3'h0, SEL_OTHER, 32'($random(seed))), 1'h1);
  endtask

  task automatic settle(input int n);
    instr_valid <= 1'h0;
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wait_ready();
    for (int k = 0; k < 40 && instr_ready_reg !== 1'h1; k++)
      @(negedge clk_sys);
    if (instr_ready_reg !== 1'h1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    logic r;
    if (clk_sys === 1'h0)
      @(posedge clk_sys);
    q_apb.push_back(x);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    r = 1'h0;
    for (int k = 0; k < 20 && !r; k++) begin
      @(negedge clk_sys);
      r = (pready_reg === 1'h1);
      @(posedge clk_sys);
    end
    if (!r) begin
      n_mismatch++;
      report_and_stop();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clk_sys);
  endtask

  // Sleep, then wake through one source: bit 4 is a partner event, bit 1 a debug request, the rest exception lines
  task automatic sleep_wake(input op_type o, input int s);
    run(o);
    settle(2);
    chk("sleeping", {30'h0, instr_ready_reg, sleeping_reg}, 32'h1);
    @(posedge clk_sys);
    wake_v <= 5'h01 << s;
    @(posedge clk_sys);
    wake_v <= 5'h00;
    wait_ready();
    chk("woken", {31'h0, sleeping_reg}, 32'h0);
  endtask

  // Starts a burst of older memory traffic of random length
  task automatic load();
    @(posedge clk_sys);
    busy_len <= 4'(3 + {$random(seed)} % 6);
    busy_start <= 1'h1;
    @(posedge clk_sys);
    busy_start <= 1'h0;
  endtask

  // Main sequence; operands are plain data, never a stack or program counter
  initial begin
    seed = 32'h985C;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(negedge clk_sys);
    chk("reset", {instr_ready_reg, sleeping_reg, interrupt_priority_mask_reg, fault_mask_a_reg,
        base_priority_threshold_reg, cond_flags_reg}, 32'h0001_0000);
    // Every mask form, privileged first, then unprivileged; never conditional
    for (int k = 15; k >= 0; k--) begin
      issue(mk(OP_MASK_CHANGE, k[2:0], SEL_OTHER, 32'($random(seed))), k[3]);
      settle(2);
      pm = (k[3] && k[1]) ? k[2] : pm;
      fm = (k[3] && k[0]) ? k[2] : fm;
      chk("masks", {interrupt_priority_mask_reg, fault_mask_a_reg, cond_flags_reg},
          {pm, fm, flags});
    end
    // Unprivileged special writes: flags load, threshold refused
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      issue(mk(OP_SPEC_WRITE, 3'h0, wsel[i], v), 1'h0);
      flags = (i < 2) ? v[31:27] : flags;
      settle(2);
      chk("flags", {base_priority_threshold_reg, cond_flags_reg}, {thr, flags});
    end
    for (int i = 0; i < 5; i++) begin
      issue(mk(OP_SPEC_WRITE, 3'h0, SEL_RAISE_ALIAS, {24'h0, alias_v[i]}), 1'h1);
      if (alias_v[i] != 8'h00 && (thr == 8'h00 || alias_v[i] < thr))
        thr = alias_v[i];
      settle(2);
      chk("threshold", {24'h0, base_priority_threshold_reg}, {24'h0, thr});
    end
    // Back-to-back reads of every selector after a direct threshold write
    issue(mk(OP_MASK_CHANGE, 3'h6, SEL_OTHER, 32'h0), 1'h1);
    issue(mk(OP_SPEC_WRITE, 3'h0, SEL_BASE_PRI, 32'h0000_0090), 1'h1);
    pm = 1'h1;
    thr = 8'h90;
    for (int s = 0; s < 12; s++) begin
      q_rd.push_back(exp_rd(spec_sel_type'(s)));
      issue(mk(OP_SPEC_READ, 3'h0, spec_sel_type'(s), 32'($random(seed))), 1'h1);
    end
    run(OP_SUPERVISOR_CALL);
    run(OP_NO_OPERATION);
    run(OP_REFETCH_BARRIER);
    run(OP_EVENT_BROADCAST);
    settle(3);
    chk("pulses", {n_svc[7:0], n_flush[7:0], n_evt[7:0]}, 32'h0001_0101);
    run(OP_EVENT_WAIT);
    settle(2);
    chk("no_sleep", {30'h0, instr_ready_reg, sleeping_reg}, 32'h2);
    sleep_wake(OP_EVENT_WAIT, 4);
    apb(1'h1, ADDR_CTRL, 32'h0000_0003, 33'h0);
    apb(1'h0, ADDR_CTRL, 32'h0, 33'h0_0000_0003);
    for (int s = 0; s < 2; s++)
      sleep_wake(OP_EVENT_WAIT, s);
    for (int s = 1; s < 4; s++)
      sleep_wake(OP_INT_WAIT, s);
    // Order barrier under load: memory held, instruction stream keeps flowing
    load();
    run(OP_ORDER_BARRIER);
    run(OP_NO_OPERATION);
    settle(1);
    chk("order", {30'h0, instr_ready_reg, mem_hold_reg}, 32'h3);
    repeat (12) @(negedge clk_sys);
    chk("released", {31'h0, mem_hold_reg}, 32'h0);
    load();
    run(OP_COMPLETE_BARRIER);
    settle(2);
    chk("draining", {30'h0, instr_ready_reg, mem_hold_reg}, 32'h1);
    wait_ready();
    chk("drained", {31'h0, mem_busy}, 32'h0);
    apb(1'h0, ADDR_STATUS, 32'h0, {1'h0, flags, 11'h0, thr, 6'h0, fm, pm});
    apb(1'h1, ADDR_STATUS, 32'hFFFF_FFFF, {1'h1, 32'h0});
    apb(1'h0, 12'h008, 32'h0, {1'h1, 32'h0});
    report_and_stop();
  end
endmodule

`default_nettype wire
